// [logic/rcc_pkg.sv]
// shared widths, field positions, encodings and reset values of the counter/calendar core
package rcc_pkg;

  // counter widths and divider select width
  localparam int PRE_WIDTH = 15;
  localparam int MAIN_WIDTH = 32;
  localparam int DIV_SEL_WIDTH = 4;

  // time_of_day_value field positions (bcd)
  localparam int SEC_U_LSB = 0;
  localparam int SEC_T_LSB = 4;
  localparam int MIN_U_LSB = 8;
  localparam int MIN_T_LSB = 12;
  localparam int HOUR_U_LSB = 16;
  localparam int HOUR_T_LSB = 20;

  // calendar_date_value field positions (bcd)
  localparam int DAY_U_LSB = 0;
  localparam int DAY_T_LSB = 4;
  localparam int MONTH_U_LSB = 8;
  localparam int MONTH_T_LSB = 12;
  localparam int YEAR_U_LSB = 16;
  localparam int YEAR_T_LSB = 20;
  localparam int WEEKDAY_LSB = 24;

  // reset values
  localparam logic [PRE_WIDTH-1:0] PRE_RESET = 15'h0000;
  localparam logic [MAIN_WIDTH-1:0] MAIN_RESET = 32'h00000000;
  localparam logic [31:0] TIME_RESET = 32'h00000000;
  // first of january, year 00, weekday 0
  localparam logic [31:0] DATE_RESET = 32'h00000101;

  // top of the main counter in plain binary operation
  localparam logic [MAIN_WIDTH-1:0] MAIN_MAX = 32'hFFFFFFFF;

  // tick source of the main counter
  typedef enum logic {
    prescaler_tick,
    channel0_match_tick
  } rcc_tick_source_type;

  // main counter operating mode
  typedef enum logic {
    binary_mode,
    calendar_mode
  } rcc_counter_mode_type;

  // whole state of the core
  typedef struct packed {
    logic lf_prev;
    logic [PRE_WIDTH-1:0] pre;
    logic [MAIN_WIDTH-1:0] main;
    logic [31:0] tod;
    logic [31:0] date;
    logic tick;
    logic time_accept;
    logic date_accept;
  } rcc_state_type;

endpackage

// [logic/rcc_tick_tap.sv]
// power-of-two tap on the pre-counter that produces the main counter tick
module rcc_tick_tap #(
  parameter int WIDTH = 15,
  parameter int SEL_WIDTH = 4
) (
  // next pre-counter value and divider select
  input wire logic [WIDTH-1:0] pre_next,
  input wire logic [SEL_WIDTH-1:0] divider_select,
  // tick when the selected low bits all return to zero
  output logic tick
);

  logic [WIDTH-1:0] mask;

  // mask of the low bits that must be zero; select 0 ticks every edge
  always_comb begin
    mask = ~({WIDTH{1'b1}} << divider_select);
    tick = ((pre_next & mask) == '0);
  end

endmodule

// [logic/rcc_month_last.sv]
// last bcd day of the current month, with leap year handling
module rcc_month_last (
  // current month and year digits
  input wire logic month_tens,
  input wire logic [3:0] month_units,
  input wire logic [3:0] year_tens,
  input wire logic [3:0] year_units,
  // suppresses the february extension
  input wire logic leap_correction_disable,
  // last day of month, tens in [5:4], units in [3:0]
  output logic [5:0] last_day,
  output logic leap_year
);

  logic [3:0] units_plus_two;

  // leap test on the bcd year, then month length lookup
  always_comb begin
    units_plus_two = year_units + 4'h2;
    if (year_tens[0] == 1'b0) begin
      leap_year = (year_units[1:0] == 2'h0); // [RULE21]
    end else begin
      leap_year = (units_plus_two[1:0] == 2'h0); // [RULE21]
    end
    if (leap_correction_disable) begin
      leap_year = 1'b0; // [RULE15]
    end
    last_day = 6'h31;
    if (month_tens == 1'b0) begin
      unique case (month_units)
        4'h2: last_day = leap_year ? 6'h29 : 6'h28; // [RULE13] [RULE15]
        4'h4, 4'h6, 4'h9: last_day = 6'h30;
        default: last_day = 6'h31;
      endcase
    end else if (month_units == 4'h1) begin
      last_day = 6'h30;
    end
  end

endmodule

// [logic/rcc_core.sv]
// counter and calendar timekeeping core with pre-counter and bcd calendar
// Function
// [RULE1] a 15-bit pre-counter and a 32-bit main counter are kept
// [RULE2] counting only while enabled; pre-counter steps on each counter clock rising edge
// [RULE3] in prescaler tick mode the pre-counter counts up and wraps to zero
// [RULE4] in channel-0 mode pre-counter wraps at compare bits 14:0 and ticks
// [RULE5] binary mode adds one to the main counter per tick
// [RULE6] prescaler tick comes from a power-of-two tap, divide 1 to 32768
// [RULE7] main counter rolls from all ones to zero by default
// [RULE8] with channel1_as_top the main counter clears when equal to channel 1 value
// [RULE9] software sets channel1_as_top before or with enabling
// [RULE10] calendar mode presents bcd time and date registers instead
// [RULE11] time register holds bcd seconds, minutes and 24-hour hours
// [RULE12] date register holds bcd day, month, year and weekday
// [RULE13] day returns to first after month end; month lengths handled
// [RULE14] three-bit weekday advances at day end and wraps after seven
// [RULE15] february gets 29 days every fourth year unless correction disabled
// [RULE16] months are one tens bit and four units bits
// [RULE17] time, date and channel calendar writes are dropped in binary mode
// [RULE18] counter writes accepted any time unless register lock engaged
// [RULE19] software selects one-second ticks for calendar operation
// [RULE20] state survives system reset; only core or software reset clears it
// [RULE21] bcd leap test on tens parity and units divisibility
// [RULE22] each tick carries seconds to years; 59 and 23 wrap points
module rcc_core (
  // clock and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic system_reset,
  // low-frequency counter clock, sampled on clk
  input wire logic low_freq_counter_clock,
  // configuration
  input wire logic enable,
  input wire logic tick_source_select,
  input wire logic [rcc_pkg::DIV_SEL_WIDTH-1:0] tick_divider_select,
  input wire logic channel1_as_top,
  input wire logic counter_mode_select,
  input wire logic leap_correction_disable,
  input wire logic register_lock,
  // compare values from the channels
  input wire logic [rcc_pkg::MAIN_WIDTH-1:0] channel0_compare_value,
  input wire logic [rcc_pkg::MAIN_WIDTH-1:0] channel1_compare_value,
  // software writes
  input wire logic prescale_write,
  input wire logic [rcc_pkg::PRE_WIDTH-1:0] prescale_write_data,
  input wire logic main_write,
  input wire logic [rcc_pkg::MAIN_WIDTH-1:0] main_write_data,
  input wire logic time_write,
  input wire logic [31:0] time_write_data,
  input wire logic date_write,
  input wire logic [31:0] date_write_data,
  input wire logic channel_time_write,
  input wire logic channel_date_write,
  // counter values
  output logic [rcc_pkg::PRE_WIDTH-1:0] prescale_count_value,
  output logic [rcc_pkg::MAIN_WIDTH-1:0] main_count_value,
  output logic [31:0] time_of_day_value,
  output logic [31:0] calendar_date_value,
  // main counter tick and channel write acceptance
  output logic main_tick,
  output logic channel_time_write_accept,
  output logic channel_date_write_accept
);

  rcc_pkg::rcc_state_type s;
  rcc_pkg::rcc_state_type next_s;

  logic lf_edge;
  logic step;
  logic cal;
  logic pre_top_hit;
  logic [rcc_pkg::PRE_WIDTH-1:0] pre_inc;
  logic tap_tick;
  logic adv;
  logic main_top_hit;
  logic pre_wr_ok;
  logic main_wr_ok;
  logic time_wr_ok;
  logic date_wr_ok;
  logic [5:0] last_day;
  logic leap_year;

  // counter clock edge and enable qualification
  always_comb begin
    lf_edge = low_freq_counter_clock & ~s.lf_prev;
    step = enable & lf_edge; // [RULE2]
    cal = (counter_mode_select == rcc_pkg::calendar_mode);
    pre_inc = s.pre + 15'h0001; // [RULE3]
    pre_top_hit = (s.pre == channel0_compare_value[rcc_pkg::PRE_WIDTH-1:0]); // [RULE4]
    main_top_hit = channel1_as_top && (s.main == channel1_compare_value); // [RULE8]
    pre_wr_ok = prescale_write & ~register_lock; // [RULE18]
    main_wr_ok = main_write & ~register_lock; // [RULE18]
    time_wr_ok = time_write & ~register_lock & cal; // [RULE17]
    date_wr_ok = date_write & ~register_lock & cal; // [RULE17]
  end

  // power-of-two tap select for prescaler ticks
  rcc_tick_tap #(
    .WIDTH(rcc_pkg::PRE_WIDTH),
    .SEL_WIDTH(rcc_pkg::DIV_SEL_WIDTH)
  ) u_tap (
    .pre_next(pre_inc),
    .divider_select(tick_divider_select),
    .tick(tap_tick)
  );

  // main counter advance from either tick source
  always_comb begin
    if (tick_source_select == rcc_pkg::channel0_match_tick) begin
      adv = step & pre_top_hit; // [RULE4]
    end else begin
      adv = step & tap_tick; // [RULE6]
    end
  end

  // month length for the current date
  rcc_month_last u_month_last (
    .month_tens(s.date[rcc_pkg::MONTH_T_LSB]),
    .month_units(s.date[rcc_pkg::MONTH_U_LSB +: 4]),
    .year_tens(s.date[rcc_pkg::YEAR_T_LSB +: 4]),
    .year_units(s.date[rcc_pkg::YEAR_U_LSB +: 4]),
    .leap_correction_disable(leap_correction_disable),
    .last_day(last_day),
    .leap_year(leap_year)
  );

  // next state: pre-counter, main counter, calendar and write handling
  always_comb begin
    logic [3:0] sec_u;
    logic [2:0] sec_t;
    logic [3:0] min_u;
    logic [2:0] min_t;
    logic [3:0] hour_u;
    logic [1:0] hour_t;
    logic [3:0] day_u;
    logic [1:0] day_t;
    logic [3:0] mon_u;
    logic mon_t;
    logic [3:0] year_u;
    logic [3:0] year_t;
    logic [2:0] weekday;
    sec_u = s.tod[rcc_pkg::SEC_U_LSB +: 4];
    sec_t = s.tod[rcc_pkg::SEC_T_LSB +: 3];
    min_u = s.tod[rcc_pkg::MIN_U_LSB +: 4];
    min_t = s.tod[rcc_pkg::MIN_T_LSB +: 3];
    hour_u = s.tod[rcc_pkg::HOUR_U_LSB +: 4];
    hour_t = s.tod[rcc_pkg::HOUR_T_LSB +: 2];
    day_u = s.date[rcc_pkg::DAY_U_LSB +: 4];
    day_t = s.date[rcc_pkg::DAY_T_LSB +: 2];
    mon_u = s.date[rcc_pkg::MONTH_U_LSB +: 4];
    mon_t = s.date[rcc_pkg::MONTH_T_LSB];
    year_u = s.date[rcc_pkg::YEAR_U_LSB +: 4];
    year_t = s.date[rcc_pkg::YEAR_T_LSB +: 4];
    weekday = s.date[rcc_pkg::WEEKDAY_LSB +: 3];
    next_s = s;
    next_s.lf_prev = low_freq_counter_clock;
    next_s.tick = adv;
    next_s.time_accept = channel_time_write & ~register_lock & cal; // [RULE17]
    next_s.date_accept = channel_date_write & ~register_lock & cal; // [RULE17]

    // pre-counter: wrap at channel 0 top or at its own overflow
    if (step) begin
      if (tick_source_select == rcc_pkg::channel0_match_tick && pre_top_hit) begin
        next_s.pre = '0; // [RULE4]
      end else begin
        next_s.pre = pre_inc; // [RULE3]
      end
    end

    // binary main counter
    if (adv && !cal) begin
      if (main_top_hit || s.main == rcc_pkg::MAIN_MAX) begin
        next_s.main = '0; // [RULE7] [RULE8]
      end else begin
        next_s.main = s.main + 32'h00000001; // [RULE5]
      end
    end

    // bcd calendar carry chain, one second per tick
    if (adv && cal) begin
      sec_u = sec_u + 4'h1; // [RULE22]
      if (sec_u == 4'hA) begin
        sec_u = 4'h0;
        sec_t = sec_t + 3'h1;
      end
      if (sec_t == 3'h6) begin
        sec_t = 3'h0;
        min_u = min_u + 4'h1;
      end
      if (min_u == 4'hA) begin
        min_u = 4'h0;
        min_t = min_t + 3'h1;
      end
      if (min_t == 3'h6) begin
        min_t = 3'h0;
        hour_u = hour_u + 4'h1;
      end
      // hours in 24-hour form
      if (hour_t == 2'h2 && hour_u == 4'h4) begin
        hour_t = 2'h0; // [RULE11]
        hour_u = 4'h0;
        weekday = (weekday == 3'h6) ? 3'h0 : weekday + 3'h1; // [RULE14]
        if ({day_t, day_u} == last_day) begin
          day_t = 2'h0; // [RULE13]
          day_u = 4'h1;
          if (mon_t == 1'b1 && mon_u == 4'h2) begin
            mon_t = 1'b0; // [RULE16]
            mon_u = 4'h1;
            year_u = year_u + 4'h1;
            if (year_u == 4'hA) begin
              year_u = 4'h0;
              year_t = (year_t == 4'h9) ? 4'h0 : year_t + 4'h1;
            end
          end else if (mon_t == 1'b0 && mon_u == 4'h9) begin
            mon_t = 1'b1; // [RULE16]
            mon_u = 4'h0;
          end else begin
            mon_u = mon_u + 4'h1;
          end
        end else begin
          day_u = day_u + 4'h1;
          if (day_u == 4'hA) begin
            day_u = 4'h0;
            day_t = day_t + 2'h1;
          end
        end
      end else if (hour_u == 4'hA) begin
        hour_u = 4'h0;
        hour_t = hour_t + 2'h1;
      end
      next_s.tod = {10'h000, hour_t, hour_u, 1'b0, min_t, min_u, 1'b0, sec_t, sec_u}; // [RULE11]
      next_s.date = {5'h00, weekday, year_t, year_u, 3'h0, mon_t, mon_u, 2'h0, day_t,
        day_u}; // [RULE12]
    end

    // software writes win over counting
    if (pre_wr_ok) begin
      next_s.pre = prescale_write_data; // [RULE18]
    end
    if (main_wr_ok) begin
      next_s.main = main_write_data; // [RULE18]
    end
    if (time_wr_ok) begin
      next_s.tod = time_write_data; // [RULE10]
    end
    if (date_wr_ok) begin
      next_s.date = date_write_data; // [RULE10]
    end
  end

  // state register; system_reset holds the state and only clears the tick and accept pulses
  always_ff @(posedge clk) begin
    if (reset || soft_reset) begin
      s.lf_prev <= 1'b0;
      s.pre <= rcc_pkg::PRE_RESET; // [RULE1]
      s.main <= rcc_pkg::MAIN_RESET; // [RULE1]
      s.tod <= rcc_pkg::TIME_RESET;
      s.date <= rcc_pkg::DATE_RESET;
      s.tick <= 1'b0;
      s.time_accept <= 1'b0;
      s.date_accept <= 1'b0;
    end else if (system_reset) begin
      s <= s; // [RULE20]
      s.tick <= 1'b0;
      s.time_accept <= 1'b0;
      s.date_accept <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  always_comb begin
    prescale_count_value = s.pre;
    main_count_value = s.main;
    time_of_day_value = s.tod;
    calendar_date_value = s.date;
    main_tick = s.tick;
    channel_time_write_accept = s.time_accept;
    channel_date_write_accept = s.date_accept;
  end

  // checks on the counting behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset || soft_reset || system_reset);

  sequence s_day_end;
    adv && cal && !time_wr_ok && !date_wr_ok && s.tod[21:0] == 22'h235959;
  endsequence

  sequence s_cal_sec;
    adv && cal && !time_wr_ok;
  endsequence

  a_pre_wraps_top: assert property ( // [RULE4]
    step && tick_source_select && pre_top_hit && !pre_wr_ok |=> s.pre == '0 && main_tick)
    else $error("pre-counter did not wrap at channel 0 top");

  a_pre_counts_up: assert property ( // [RULE3]
    step && !tick_source_select && !pre_wr_ok |=> s.pre == $past(s.pre) + 15'h0001)
    else $error("pre-counter did not step");

  a_idle_holds: assert property ( // [RULE2]
    !enable && !pre_wr_ok && !main_wr_ok [*2] |=> $stable(s.pre) && $stable(s.main))
    else $error("counters moved while disabled");

  a_main_binary_inc: assert property ( // [RULE5]
    adv && !cal && !main_wr_ok && !main_top_hit && s.main != rcc_pkg::MAIN_MAX
    |=> s.main == $past(s.main) + 32'h00000001 && main_tick)
    else $error("main counter did not step on tick");

  a_main_ch1_top: assert property ( // [RULE8]
    adv && !cal && !main_wr_ok && main_top_hit |=> s.main == '0)
    else $error("main counter did not clear at channel 1 value");

  a_time_write_drop: assert property ( // [RULE17]
    time_write && !cal |=> $stable(s.tod) && !channel_time_write_accept)
    else $error("calendar write taken in binary mode");

  a_lock_blocks: assert property ( // [RULE18]
    register_lock && main_write && !adv |=> $stable(s.main))
    else $error("locked write changed main counter");

  a_sec_wrap: assert property ( // [RULE22]
    s_cal_sec and (s.tod[6:0] == 7'h59 && !date_wr_ok) |=> s.tod[6:0] == 7'h00)
    else $error("seconds did not wrap at 59");

  a_weekday_wrap: assert property ( // [RULE14]
    s_day_end and (s.date[26:24] == 3'h6) |=> s.date[26:24] == 3'h0)
    else $error("weekday did not wrap after seven days");

  a_leap_feb: assert property ( // [RULE15]
    s_day_end and (s.date[12:0] == 13'h0228 && leap_year) |=> s.date[12:0] == 13'h0229)
    else $error("february 29 skipped in leap year");

  // channel calendar write answered one cycle later
  a_accept_pulse: assert property ( // [RULE17]
    channel_date_write && cal && !register_lock |=> channel_date_write_accept)
    else $error("channel date write not accepted in calendar mode");

  a_year_wrap: assert property ( // [RULE13]
    s_day_end and (s.date[23:0] == 24'h991231) |=> s.date[23:0] == 24'h000101)
    else $error("new year did not start on first of january");

endmodule

// [verification/tb_rcc_core.sv]
// self-checking bench for the counter and calendar core
module tb_rcc_core;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, resets and configuration
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic soft_reset = 1'h0;
  logic system_reset = 1'h0;
  logic lf = 1'h0;
  logic enable = 1'h0;
  logic src = 1'h0;
  logic [rcc_pkg::DIV_SEL_WIDTH-1:0] div = '0;
  logic top1 = 1'h0;
  logic cal = 1'h0;
  logic ldis = 1'h0;
  logic lock = 1'h0;
  logic [31:0] ccv0 = '0;
  logic [31:0] ccv1 = '0;
  // strobes: prescale, main, time, date; channel time, channel date
  logic [3:0] wr_stb = '0;
  logic [31:0] wr_data = '0;
  logic [1:0] ch_stb = '0;
  // observed outputs
  logic [rcc_pkg::PRE_WIDTH-1:0] pre;
  logic [31:0] main;
  logic [31:0] tod;
  logic [31:0] date;
  logic tick;
  logic t_acc;
  logic d_acc;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  // carry cases inside one day
  localparam logic [31:0] TIN [3] = '{32'h00000009, 32'h00000059, 32'h00095959};
  localparam logic [31:0] TOUT [3] = '{32'h00000010, 32'h00000100, 32'h00100000};
  // month-end corners: leap february, new year, no-leap february, september
  localparam int CM [4] = '{2, 12, 2, 9};
  localparam int CY [4] = '{4, 99, 4, 0};

  // device under test
  rcc_core i_rcc_core (
    .clk(clk), .reset(reset), .soft_reset(soft_reset), .system_reset(system_reset),
    .low_freq_counter_clock(lf), .enable(enable), .tick_source_select(src),
    .tick_divider_select(div), .channel1_as_top(top1), .counter_mode_select(cal),
    .leap_correction_disable(ldis), .register_lock(lock),
    .channel0_compare_value(ccv0), .channel1_compare_value(ccv1),
    .prescale_write(wr_stb[0]), .prescale_write_data(wr_data[14:0]),
    .main_write(wr_stb[1]), .main_write_data(wr_data),
    .time_write(wr_stb[2]), .time_write_data(wr_data),
    .date_write(wr_stb[3]), .date_write_data(wr_data),
    .channel_time_write(ch_stb[0]), .channel_date_write(ch_stb[1]),
    .prescale_count_value(pre), .main_count_value(main),
    .time_of_day_value(tod), .calendar_date_value(date), .main_tick(tick),
    .channel_time_write_accept(t_acc), .channel_date_write_accept(d_acc)
  );

  // 100 MHz clock
  always #5 clk = ~clk;

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one register write strobe
  task automatic wr(input int idx, input logic [31:0] d);
    @(negedge clk);
    wr_stb[idx] = 1'h1;
    wr_data = d;
    @(negedge clk);
    wr_stb = '0;
    @(negedge clk);
  endtask

  // channel calendar write, acceptance pulse looked for
  task automatic chw(input int idx, input logic eacc);
    logic acc;
    acc = 1'h0;
    @(negedge clk);
    ch_stb[idx] = 1'h1;
    @(negedge clk);
    ch_stb = '0;
    repeat (2) begin
      acc = acc | ((idx == 1) ? d_acc : t_acc);
      @(negedge clk);
    end
    chk(32'(acc), 32'(eacc));
  endtask

  // one counter clock period, any tick pulse caught
  task automatic lf_pulse(output logic tk);
    tk = 1'h0;
    @(negedge clk);
    lf = 1'h1;
    repeat (3) begin
      @(negedge clk);
      tk = tk | tick;
    end
    lf = 1'h0;
  endtask

  // binary step with expected tick, pre and main
  task automatic step(input logic etk, input logic [31:0] epre, input logic [31:0] emain);
    logic tk;
    lf_pulse(tk);
    chk(32'(tk), 32'(etk));
    chk(32'(pre), epre);
    chk(main, emain);
  endtask

  // calendar step with expected time and date
  task automatic cal_step(input logic [31:0] et, input logic [31:0] ed);
    logic tk;
    wr(0, 32'h00007FFF);
    lf_pulse(tk);
    chk(32'(tk), 32'h00000001);
    chk(tod, et);
    chk(date, ed);
  endtask

  // cleared state
  task automatic chk_idle();
    chk(32'(pre), 32'h0);
    chk(main, 32'h0);
    chk(tod, 32'h0);
    chk(date, 32'h00000101);
  endtask

  // days in a month with the bcd leap test
  function automatic int last_day(int m, int y, logic nol);
    if (m == 2) begin
      if (!nol && ((y / 10) % 2 == 0 ? (y % 10) % 4 == 0 : (y % 10 + 2) % 4 == 0)) return 29;
      return 28;
    end
    if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
    return 31;
  endfunction

  // two bcd digits
  function automatic logic [7:0] bcd(int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction

  // date word layout
  function automatic logic [31:0] pack_date(int d, int m, int y, int w);
    return {5'h00, 3'(w), bcd(y), 3'h0, 5'(bcd(m)), 2'h0, 6'(bcd(d))};
  endfunction

  // main sequence
  initial begin
    int p;
    int tp;
    int d;
    int m;
    int y;
    int w;
    logic [31:0] mn;
    logic tk;
    void'($urandom(32'h1E87182E));
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset = 1'h0;
    chk_idle();
    // nothing counts while disabled
    step(1'h0, 32'h0, 32'h0);
    enable = 1'h1;
    step(1'h1, 32'h1, 32'h1);
    // every divider code with a tap carry, codes 1 to 15 also without one
    for (int k = 0; k < 16; k++) begin
      div = 4'(k);
      p = ($urandom & 32'h7FFF) | ((1 << k) - 1);
      mn = $urandom;
      wr(0, 32'(p));
      wr(1, mn);
      step(1'h1, 32'((p + 1) & 32'h7FFF), mn + 32'h1);
      if (k > 0) begin
        wr(0, 32'(p - 1));
        step(1'h0, 32'(p), mn + 32'h1);
      end
    end
    // all-ones rollover
    div = '0;
    wr(0, 32'h0);
    wr(1, 32'hFFFFFFFF);
    step(1'h1, 32'h1, 32'h0);
    // channel 1 top, set together with enable
    enable = 1'h0;
    ccv1 = $urandom_range(100000, 2);
    wr(1, ccv1 - 32'h1);
    top1 = 1'h1;
    enable = 1'h1;
    step(1'h1, 32'h2, ccv1);
    step(1'h1, 32'h3, 32'h0);
    // writes refused while locked
    lock = 1'h1;
    wr(0, 32'h1234);
    wr(1, 32'h5555);
    step(1'h1, 32'h4, 32'h1);
    lock = 1'h0;
    top1 = 1'h0;
    // state frozen and kept across a system reset
    wr(0, 32'h0123);
    wr(1, 32'hA5A50001);
    system_reset = 1'h1;
    lf_pulse(tk);
    chk(32'(tk), 32'h0);
    chk(32'(pre), 32'h0123);
    chk(main, 32'hA5A50001);
    system_reset = 1'h0;
    step(1'h1, 32'h0124, 32'hA5A50002);
    // channel 0 low bits as pre-counter top
    src = 1'h1;
    repeat (4) begin
      tp = $urandom_range(32767, 1);
      ccv0 = {17'($urandom), 15'(tp)};
      mn = $urandom;
      wr(0, 32'(tp - 1));
      wr(1, mn);
      step(1'h0, 32'(tp), mn);
      step(1'h1, 32'h0, mn + 32'h1);
    end
    src = 1'h0;
    // calendar writes dropped in binary mode
    wr(2, 32'h00123456);
    wr(3, 32'h00031215);
    chk(tod, 32'h0);
    chk(date, 32'h00000101);
    chw(0, 1'h0);
    chw(1, 1'h0);
    // calendar mode on the one-second tap; each step preloads the pre-counter top
    cal = 1'h1;
    div = 4'hF;
    chw(0, 1'h1);
    chw(1, 1'h1);
    wr(3, 32'h00000315);
    for (int i = 0; i < 3; i++) begin
      wr(2, TIN[i]);
      cal_step(TOUT[i], 32'h00000315);
    end
    for (int i = 0; i < 16; i++) begin
      y = (i < 4) ? CY[i] : $urandom_range(99);
      m = (i < 4) ? CM[i] : $urandom_range(12, 1);
      ldis = (i < 4) ? (i == 2) : 1'($urandom);
      w = (i == 1) ? 6 : $urandom_range(6);
      d = last_day(m, y, ldis) - ((i == 0) ? 1 : 0);
      wr(2, 32'h00235959);
      wr(3, pack_date(d, m, y, w));
      if (d == last_day(m, y, ldis)) begin
        d = 1;
        y = (m == 12) ? (y + 1) % 100 : y;
        m = (m == 12) ? 1 : m + 1;
      end else begin
        d++;
      end
      cal_step(32'h0, pack_date(d, m, y, (w + 1) % 7));
    end
    // software reset clears everything
    soft_reset = 1'h1;
    repeat (2) @(negedge clk);
    soft_reset = 1'h0;
    chk_idle();
    conclude();
  end
endmodule
